//--- hdl/stable_repeat_consts.vh
// Purpose: Constants for the stable-weight repeat-on-change command handler
// Assumes: Weights are signed counts of one display digit of the selected unit
// Notes:   Included by stable_weight_repeat_on_change.v, the checker and the bench
`ifndef STABLE_REPEAT_CONSTS_VH
`define STABLE_REPEAT_CONSTS_VH

// ----------------------------------------------------------------------------
// Command codes on cmd_code
// ----------------------------------------------------------------------------
`define CMD_CANCEL        3'h0
`define CMD_ON_CHANGE_HST 3'h1
`define CMD_ON_CHANGE_SHN 3'h2
`define CMD_OTHER_WEIGHT  3'h3

// ----------------------------------------------------------------------------
// Reply kinds on resp_kind
// ----------------------------------------------------------------------------
`define RESP_NONE   3'h0
`define RESP_STABLE 3'h1
`define RESP_BUSY   3'h2
`define RESP_PARAM  3'h3
`define RESP_OVER   3'h4
`define RESP_UNDER  3'h5

// ----------------------------------------------------------------------------
// Default deflection in digits, indexed by readability code 0..6
// (0.001 mg, 0.01 mg, 0.1 mg, 0.001 g, 0.01 g, 0.1 g, 1 g)
// ----------------------------------------------------------------------------
`define DEFL_READ_0 24'h0003e8
`define DEFL_READ_1 24'h0003e8
`define DEFL_READ_2 24'h0003e8
`define DEFL_READ_3 24'h0003e8
`define DEFL_READ_4 24'h000064
`define DEFL_READ_5 24'h00000a
`define DEFL_READ_6 24'h000005

// ----------------------------------------------------------------------------
// Timing and format
// ----------------------------------------------------------------------------
`define CLK_KHZ          40000
`define STABLE_TMO_MS    1000
`define FIELD_CHARS      10
`define CHAR_SPACE       8'h20
`define CHAR_MINUS       8'h2d
`define CHAR_POINT       8'h2e
`define CHAR_ZERO        8'h30

`endif

//--- hdl/stable_weight_repeat_on_change.v
// Purpose: Streams stable weight replies, repeating after each load deflection
// Assumes: Commands arrive already parsed; preset is in digits of selected unit
// Notes:   Any new command aborts a reply that is still waiting for resp_ready
//
// Operation
// - Host-unit command reports stable weight, then repeats
// - Shown-unit variant reports in displayed unit
// - Streaming continues until stopped
// - Later reports follow deflection and stability
// - Preset triggers on deflection at least preset
// - Preset from one digit to capacity
// - Without preset, deflection follows readability table
// - Never report non-stable weights
// - Busy or stability timeout gives busy reply
// - Invalid argument gives parameter reply
// - Overload and underload replies replace weight
// - Cancel or other weight command ends stream
// - Weight field is ten right-aligned characters
`timescale 1ns/1ps
`include "stable_repeat_consts.vh"

module stable_weight_repeat_on_change #(
    parameter W       = 24,
    parameter TMO_CYC = `STABLE_TMO_MS * `CLK_KHZ
) (
    // Clock and reset
    input  wire                clk,
    input  wire                nrst,
    // Parsed command
    input  wire                cmd_valid,
    input  wire [2:0]          cmd_code,
    input  wire                preset_present,
    input  wire                preset_unit_ok,
    input  wire [W-1:0]        preset_value,
    // Balance state
    input  wire [W-1:0]        capacity,
    input  wire [2:0]          readability,
    input  wire [2:0]          decimals,
    input  wire                busy,
    input  wire                stable,
    input  wire                overload,
    input  wire                underload,
    input  wire signed [W:0]   weight_host,
    input  wire signed [W:0]   weight_shown,
    // Reply
    input  wire                resp_ready,
    output reg                 resp_valid_q,
    output reg  [2:0]          resp_kind_q,
    output reg                 resp_shown_q,
    output reg  [79:0]         resp_field_q,
    output reg                 streaming_q
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // State and working registers
    // ------------------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_FIRST = 3'd1;
    localparam S_CONV  = 3'd2;
    localparam S_SEND  = 3'd3;
    localparam S_WATCH = 3'd4;

    reg [2:0]        state_q;
    reg              got_first_q;
    reg              range_rep_q;
    reg [W-1:0]      thr_q;
    reg signed [W:0] ref_q;
    reg [31:0]       tmo_q;
    reg [W-1:0]      bin_q;
    reg [31:0]       bcd_q;
    reg [4:0]        cnt_q;
    reg              neg_q;

    wire signed [W:0]   weight_sel = resp_shown_q ? weight_shown : weight_host;
    wire signed [W+1:0] diff       = {weight_sel[W], weight_sel} - {ref_q[W], ref_q};
    wire [W+1:0]        diff_abs   = diff[W+1] ? (~diff + 1'b1) : diff;
    wire [W:0]          sel_abs    = weight_sel[W] ? (~weight_sel + 1'b1) : weight_sel;

    reg [W-1:0] defl_default;
    always @* begin
        case (readability)
            3'd0:    defl_default = `DEFL_READ_0;
            3'd1:    defl_default = `DEFL_READ_1;
            3'd2:    defl_default = `DEFL_READ_2;
            3'd3:    defl_default = `DEFL_READ_3;
            3'd4:    defl_default = `DEFL_READ_4;
            3'd5:    defl_default = `DEFL_READ_5;
            default: defl_default = `DEFL_READ_6;
        endcase
    end

    // ------------------------------------------------------------------------
    // Binary to BCD step, one bit per cycle
    // ------------------------------------------------------------------------
    reg [31:0] bcd_adj;
    integer    n;
    always @* begin
        bcd_adj = bcd_q;
        for (n = 0; n < 8; n = n + 1) begin
            if (bcd_adj[n*4 +: 4] >= 4'd5) begin
                bcd_adj[n*4 +: 4] = bcd_adj[n*4 +: 4] + 4'd3;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Field build: leading blanks, sign, digits, point
    // ------------------------------------------------------------------------
    reg [79:0] field;
    reg [3:0]  msd;
    reg [3:0]  dig;
    reg        sign_done;
    integer    pos;
    integer    k;
    always @* begin
        field     = {10{`CHAR_SPACE}};
        msd       = 4'd0;
        dig       = 4'd0;
        sign_done = 1'b0;
        k         = 0;
        for (pos = 0; pos < 8; pos = pos + 1) begin
            if (bcd_q[pos*4 +: 4] != 4'd0) begin
                msd = pos[3:0];
            end
        end
        for (pos = 0; pos < `FIELD_CHARS; pos = pos + 1) begin
            if (decimals != 3'd0 && pos == decimals) begin
                field[pos*8 +: 8] = `CHAR_POINT;
            end else if (k < 8 && (k <= msd || k <= decimals)) begin
                dig               = bcd_q[k*4 +: 4];
                field[pos*8 +: 8] = `CHAR_ZERO + {4'h0, dig};
                k                 = k + 1;
            end else if (neg_q && !sign_done) begin
                field[pos*8 +: 8] = `CHAR_MINUS;
                sign_done         = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command handling and streaming
    // ------------------------------------------------------------------------
    wire is_family = (cmd_code == `CMD_ON_CHANGE_HST) || (cmd_code == `CMD_ON_CHANGE_SHN);
    wire bad_arg   = preset_present &&
                     (!preset_unit_ok || preset_value == {W{1'b0}} || preset_value > capacity);
    wire tmo_hit   = (tmo_q >= TMO_CYC - 1);

    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q      <= S_IDLE;
            got_first_q  <= 1'b0;
            range_rep_q  <= 1'b0;
            thr_q        <= {W{1'b0}};
            ref_q        <= {(W+1){1'b0}};
            tmo_q        <= 32'h0000_0000;
            bin_q        <= {W{1'b0}};
            bcd_q        <= 32'h0000_0000;
            cnt_q        <= 5'h00;
            neg_q        <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_kind_q  <= `RESP_NONE;
            resp_shown_q <= 1'b0;
            resp_field_q <= 80'h0;
            streaming_q  <= 1'b0;
        end else if (cmd_valid) begin
            resp_valid_q <= 1'b0;
            got_first_q  <= 1'b0;
            range_rep_q  <= 1'b0;
            tmo_q        <= 32'h0000_0000;
            streaming_q  <= 1'b0;
            state_q      <= S_IDLE;
            if (is_family) begin
                resp_shown_q <= (cmd_code == `CMD_ON_CHANGE_SHN);
                if (busy) begin
                    resp_kind_q  <= `RESP_BUSY;
                    resp_field_q <= 80'h0;
                    resp_valid_q <= 1'b1;
                    state_q      <= S_SEND;
                end else if (bad_arg) begin
                    resp_kind_q  <= `RESP_PARAM;
                    resp_field_q <= 80'h0;
                    resp_valid_q <= 1'b1;
                    state_q      <= S_SEND;
                end else begin
                    thr_q       <= preset_present ? preset_value : defl_default;
                    streaming_q <= 1'b1;
                    state_q     <= S_FIRST;
                end
            end
        end else begin
            case (state_q)
                S_IDLE: begin
                    streaming_q <= 1'b0;
                end
                S_FIRST, S_WATCH: begin
                    if (state_q == S_FIRST) begin
                        tmo_q <= tmo_q + 32'h1;
                    end
                    if (!overload && !underload) begin
                        range_rep_q <= 1'b0;
                    end
                    if ((overload || underload) && !range_rep_q) begin
                        range_rep_q  <= 1'b1;
                        resp_kind_q  <= overload ? `RESP_OVER : `RESP_UNDER;
                        resp_field_q <= 80'h0;
                        resp_valid_q <= 1'b1;
                        state_q      <= S_SEND;
                    end else if (overload || underload) begin
                        state_q <= state_q;
                    end else if (stable && (state_q == S_FIRST || diff_abs >= {2'b00, thr_q})) begin
                        ref_q   <= weight_sel;
                        neg_q   <= weight_sel[W];
                        bin_q   <= sel_abs[W-1:0];
                        bcd_q   <= 32'h0000_0000;
                        cnt_q   <= 5'h00;
                        state_q <= S_CONV;
                    end else if (state_q == S_FIRST && tmo_hit) begin
                        resp_kind_q  <= `RESP_BUSY;
                        resp_field_q <= 80'h0;
                        resp_valid_q <= 1'b1;
                        streaming_q  <= 1'b0;
                        state_q      <= S_SEND;
                    end
                end
                S_CONV: begin
                    bcd_q <= {bcd_adj[30:0], bin_q[W-1]};
                    bin_q <= {bin_q[W-2:0], 1'b0};
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == W - 1) begin
                        state_q <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (!resp_valid_q) begin
                        resp_kind_q  <= `RESP_STABLE;
                        resp_field_q <= field;
                        resp_valid_q <= 1'b1;
                        got_first_q  <= 1'b1;
                    end else if (resp_ready) begin
                        resp_valid_q <= 1'b0;
                        if (!streaming_q) begin
                            state_q <= S_IDLE;
                        end else if (got_first_q) begin
                            state_q <= S_WATCH;
                        end else begin
                            state_q <= S_FIRST;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

//--- test/host_model.sv
// Purpose: Host that accepts replies, promptly or one cycle in four
// Assumes: Reply is taken at the rising edge where valid and ready meet
// Notes:   Keeps the last accepted reply and a count of them
`timescale 1ns/1ps

module host_model (
    // Clock and mode
    input wire          clk,
    input wire          slow,
    // Reply from the handler
    input wire          resp_valid_q,
    input wire [2:0]    resp_kind_q,
    input wire          resp_shown_q,
    input wire [79:0]   resp_field_q,
    output logic        resp_ready,
    // Last accepted reply
    output int          n_acc,
    output logic [2:0]  kind,
    output logic        shown,
    output logic [79:0] field
);
    int cyc;
    initial begin
        cyc = 0;
        n_acc = 0;
        resp_ready = 1'b0;
    end
    // Stalling host makes a pending reply wait
    always @(negedge clk) begin
        cyc <= cyc + 1;
        resp_ready <= !slow || (cyc % 4 == 3);
    end
    always @(posedge clk) begin
        if (resp_valid_q && resp_ready) begin
            kind <= resp_kind_q;
            shown <= resp_shown_q;
            field <= resp_field_q;
            n_acc <= n_acc + 1;
        end
    end
endmodule

//--- test/swr_checker.sv
// Purpose: Port-level assertions for the stable repeat-on-change handler
// Assumes: Commands are sent only once the internal reset copy has released
// Notes:   Bound to every instance of the handler
`timescale 1ns/1ps
`include "stable_repeat_consts.vh"

module swr_checker #(
    parameter W       = 24,
    parameter TMO_CYC = 50
) (
    // Clock and command
    input wire         clk,
    input wire         nrst,
    input wire         cmd_valid,
    input wire [2:0]   cmd_code,
    input wire         preset_present,
    input wire         preset_unit_ok,
    input wire [W-1:0] preset_value,
    // Balance state
    input wire [W-1:0] capacity,
    input wire         busy,
    input wire         stable,
    input wire         overload,
    input wire         underload,
    // Reply
    input wire         resp_ready,
    input wire         resp_valid_q,
    input wire [2:0]   resp_kind_q,
    input wire [79:0]  resp_field_q,
    input wire         streaming_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire fam = cmd_valid && (cmd_code == `CMD_ON_CHANGE_HST || cmd_code == `CMD_ON_CHANGE_SHN);
    wire bad = preset_present && (!preset_unit_ok || preset_value == 0 || preset_value > capacity);
    wire stop = cmd_valid && (cmd_code == `CMD_CANCEL || cmd_code == `CMD_OTHER_WEIGHT);

    a_busy_reply: assert property (fam && busy |=> resp_valid_q && resp_kind_q == `RESP_BUSY && !streaming_q)
        else $error("busy command did not give the busy reply");
    a_param_reply: assert property (fam && !busy && bad |=> resp_valid_q && resp_kind_q == `RESP_PARAM && !streaming_q)
        else $error("bad preset did not give the parameter reply");
    a_stream_start: assert property (fam && !busy && !bad |=> streaming_q && !resp_valid_q)
        else $error("valid command did not start a stream");
    a_stop_cmd: assert property (stop |=> !streaming_q && !resp_valid_q)
        else $error("stopping command left the stream running");
    a_first_report: assert property ($rose(streaming_q) && stable && !overload && !underload
        |-> ##[1:30] (resp_valid_q && resp_kind_q == `RESP_STABLE))
        else $error("first stable report missing");
    a_stable_only: assert property ($rose(resp_valid_q) && resp_kind_q == `RESP_STABLE
        |-> $past(stable, 25) || $past(stable, 26) || $past(stable, 27))
        else $error("weight report without stability");
    a_nonweight_zero: assert property (resp_valid_q && resp_kind_q != `RESP_STABLE |-> resp_field_q == 80'h0)
        else $error("non-weight reply carries a field");
    a_overload_reply: assert property ($rose(overload) && streaming_q && !cmd_valid && !resp_valid_q
        |=> resp_valid_q && resp_kind_q == `RESP_OVER)
        else $error("overload reply missing");

    cover property (fam && busy);
    cover property ($rose(overload) && streaming_q);
    cover property (resp_valid_q && resp_ready && resp_kind_q == `RESP_STABLE);
endmodule

bind stable_weight_repeat_on_change swr_checker #(.W(W), .TMO_CYC(TMO_CYC)) swr_checker_i (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .preset_present(preset_present),
    .preset_unit_ok(preset_unit_ok), .preset_value(preset_value), .capacity(capacity), .busy(busy),
    .stable(stable), .overload(overload), .underload(underload), .resp_ready(resp_ready),
    .resp_valid_q(resp_valid_q), .resp_kind_q(resp_kind_q), .resp_field_q(resp_field_q),
    .streaming_q(streaming_q));

//--- test/tb_stable_weight_repeat_on_change.sv
// Purpose: Self-checking bench for the stable repeat-on-change handler
// Assumes: Two decimals unless a scenario changes them, fixed capacity, short timeout
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
`include "stable_repeat_consts.vh"

module tb_stable_weight_repeat_on_change;
    logic               clk = 0, nrst = 0, cmd_valid = 0, preset_present = 0, preset_unit_ok = 0;
    logic [2:0]         cmd_code = 0, readability = 0, decimals = 3'h2;
    logic [23:0]        preset_value = 0;
    logic               busy = 0, stable = 1, overload = 0, underload = 0, slow = 0;
    logic signed [24:0] weight_host = 0, weight_shown = 0;
    wire                resp_ready, resp_valid_q, resp_shown_q, streaming_q, shown;
    wire [2:0]          resp_kind_q, kind;
    wire [79:0]         resp_field_q, field;
    wire [23:0]         capacity = 24'h0f4240;
    int                 n_acc, num_errors = 0, n_tests = 0, cyc = 0;
    int                 thr_t[7] = '{1000, 1000, 1000, 1000, 100, 10, 5};

    stable_weight_repeat_on_change #(.W(24), .TMO_CYC(50)) stable_weight_repeat_on_change_i (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .preset_present(preset_present),
        .preset_unit_ok(preset_unit_ok), .preset_value(preset_value), .capacity(capacity),
        .readability(readability), .decimals(decimals), .busy(busy), .stable(stable), .overload(overload),
        .underload(underload), .weight_host(weight_host), .weight_shown(weight_shown), .resp_ready(resp_ready),
        .resp_valid_q(resp_valid_q), .resp_kind_q(resp_kind_q), .resp_shown_q(resp_shown_q),
        .resp_field_q(resp_field_q), .streaming_q(streaming_q));
    host_model host_model_i (.clk(clk), .slow(slow), .resp_valid_q(resp_valid_q), .resp_kind_q(resp_kind_q),
        .resp_shown_q(resp_shown_q), .resp_field_q(resp_field_q), .resp_ready(resp_ready), .n_acc(n_acc),
        .kind(kind), .shown(shown), .field(field));

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // Ten right-aligned characters, blanked leading zeros, point set by decimals
    function automatic logic [79:0] fmt(input int v);
        logic [79:0] f;
        int          a, i;
        bit          neg;
        f = {10{8'h20}};
        neg = v < 0;
        a = neg ? -v : v;
        for (i = 0; i < 10; i++) begin
            if (decimals != 0 && i == int'(decimals)) f[i*8+:8] = 8'h2e;
            else if (a != 0 || i <= int'(decimals) + int'(decimals != 0)) begin
                f[i*8+:8] = 8'h30 + 8'(a % 10);
                a = a / 10;
            end else if (neg) begin
                f[i*8+:8] = 8'h2d;
                neg = 0;
            end
        end
        return f;
    endfunction

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [2:0] c, input logic pp, input logic uok, input logic [23:0] pv);
        @(negedge clk);
        cmd_valid = 1;
        cmd_code = c;
        preset_present = pp;
        preset_unit_ok = uok;
        preset_value = pv;
        @(negedge clk);
        cmd_valid = 0;
    endtask
    task automatic expect_reply(input logic [2:0] k, input logic sh, input logic [79:0] f);
        int n0, i;
        n0 = n_acc;
        for (i = 0; i < 100 && n_acc == n0; i++) @(negedge clk);
        chk(80'(n_acc - n0), 80'h1);
        chk(kind, k);
        chk(field, f);
        if (k == `RESP_STABLE) chk(shown, sh);
    endtask
    task automatic expect_none(input int n);
        int n0;
        n0 = n_acc;
        repeat (n) @(negedge clk);
        chk(80'(n_acc - n0), 80'h0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_readability;
        int r, t;
        for (r = 0; r < 7; r++) begin
            readability = 3'(r);
            t = thr_t[r];
            weight_host = 100;
            weight_shown = -7;
            send(`CMD_ON_CHANGE_HST, 0, 0, 0);
            expect_reply(`RESP_STABLE, 0, fmt(100));
            weight_host = 25'(100 + t - 1);
            expect_none(40);
            weight_host = 25'(100 + t);
            expect_reply(`RESP_STABLE, 0, fmt(100 + t));
            weight_host = 25'(100 + 2 * t - 1);
            expect_none(40);
            send(`CMD_CANCEL, 0, 0, 0);
            chk(streaming_q, 0);
        end
        $display("test readability done");
    endtask
    task automatic t_shown_preset;
        slow = 1;
        weight_shown = -1234;
        weight_host = 5;
        send(`CMD_ON_CHANGE_SHN, 1, 1, 24'h32);
        expect_reply(`RESP_STABLE, 1, fmt(-1234));
        stable = 0;
        weight_shown = -1174;
        expect_none(60);
        stable = 1;
        expect_reply(`RESP_STABLE, 1, fmt(-1174));
        weight_shown = -1223;
        expect_none(40);
        weight_shown = -1224;
        expect_reply(`RESP_STABLE, 1, fmt(-1224));
        overload = 1;
        expect_reply(`RESP_OVER, 0, 0);
        overload = 0;
        expect_none(10);
        underload = 1;
        expect_reply(`RESP_UNDER, 0, 0);
        underload = 0;
        send(`CMD_OTHER_WEIGHT, 0, 0, 0);
        chk(streaming_q, 0);
        slow = 0;
        $display("test shown unit done");
    endtask
    task automatic t_refuse;
        logic [23:0] pv[4] = '{24'h5, 24'h0, 24'h0f4241, 24'h5};
        logic [3:0]  uk = 4'b0111;
        int          i;
        for (i = 0; i < 4; i++) begin
            busy = (i == 0);
            send(3'(i % 2 + 1), i != 0, uk[i], pv[i]);
            expect_reply(i == 0 ? `RESP_BUSY : `RESP_PARAM, 0, 0);
            chk(streaming_q, 0);
        end
        busy = 0;
        send(`CMD_ON_CHANGE_HST, 1, 1, capacity);
        expect_reply(`RESP_STABLE, 0, fmt(5));
        $display("test refusals done");
    endtask
    task automatic t_timeout;
        stable = 0;
        send(`CMD_ON_CHANGE_HST, 0, 0, 0);
        chk(streaming_q, 1);
        expect_none(40);
        expect_reply(`RESP_BUSY, 0, 0);
        chk(streaming_q, 0);
        $display("test timeout done");
    endtask
    task automatic t_decimals;
        stable = 1;
        readability = 3'h6;
        decimals = 3'h0;
        weight_host = 5;
        send(`CMD_ON_CHANGE_HST, 0, 0, 0);
        expect_reply(`RESP_STABLE, 0, fmt(5));
        decimals = 3'h3;
        weight_host = -7;
        expect_reply(`RESP_STABLE, 0, fmt(-7));
        send(`CMD_CANCEL, 0, 0, 0);
        chk(streaming_q, 0);
        $display("test decimals done");
    endtask

    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge clk);
        nrst = 1;
        repeat (4) @(negedge clk);
        t_readability();
        t_shown_preset();
        t_refuse();
        t_timeout();
        t_decimals();
        summarize();
    end
endmodule
